// ---- shared/mfp_defines.svh ----
// offsets, field positions, reset values and timing counts of the multifunction pin block
`ifndef MFP_DEFINES_SVH
`define MFP_DEFINES_SVH
`define MFP_NCH 4
`define MFP_ADDR_TRIG 8'h21
`define MFP_ADDR_STATUS 8'h23
`define MFP_ADDR_CONFIG 8'h24
`define MFP_CFG_RESET 16'h0000
`define MFP_STATUS_RESET 16'h0000
`define MFP_RDATA_IDLE 16'h0000
`define MFP_ST_CMP_LSB 0
`define MFP_ST_WIN_LSB 4
`define MFP_ST_PROTECT 8
`define MFP_ST_TOP 15
`define MFP_TRIG_CLR_TOP 15
`define MFP_TRIG_STRIDE 4
`define MFP_OSEL_NVM 4'h1
`define MFP_OSEL_BUSY_HI 2'h1
`define MFP_OSEL_WIN_HI 2'h2
`define MFP_FILTER_NS 100
`define MFP_CLK_NS 25
`endif

// ---- shared/mfp_pkg.sv ----
// types shared by the multifunction pin block
package mfp_pkg;
   typedef enum logic [3:0] {
      MFP_IN_SLEEP = 4'h0,
      MFP_IN_SNAP = 4'h2,
      MFP_IN_CURRENT_OUTPUT = 4'h3,
      MFP_IN_VOLTAGE_OUTPUT = 4'h4,
      MFP_IN_PROTECT = 4'h5,
      MFP_IN_CLEAR = 4'h7,
      MFP_IN_LOAD = 4'h8,
      MFP_IN_WAVE = 4'h9,
      MFP_IN_MARGIN = 4'ha,
      MFP_IN_RESET = 4'hb,
      MFP_IN_NVM_WP = 4'hc,
      MFP_IN_LOCK = 4'hd
   } mfp_in_func_t;
   typedef struct packed {
      logic input_filter_on;
      logic low_power_sleep_allow;
      logic pin_output_on;
      logic [3:0] pin_output_select;
      logic [3:0] input_channel_mask;
      logic [3:0] pin_input_function;
      logic pin_input_on;
   } mfp_cfg_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } mfp_reg_req_t;
   typedef struct packed {
      logic [3:0] current_output_off;
      logic [3:0] voltage_output_off;
      logic [3:0] wave_run;
      logic [3:0] load_strobe;
      logic [3:0] margin_low;
      logic [3:0] margin_high;
   } mfp_chan_act_t;
endpackage

// ---- hdl/mfp_pin_sync.sv ----
// three-stage synchroniser whose output moves once stages two and three agree
module mfp_pin_sync #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] out_q;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         out_q <= '0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // a bit still disagreeing between stages keeps its old value
         out_q <= (s2_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
      end
   end
   assign sync_out = out_q;
endmodule

// ---- hdl/mfp_glitch_filter.sv ----
// glitch filter: the output follows the input once it has stood for CYCLES cycles
module mfp_glitch_filter #(
   parameter int CYCLES = 4
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic d_in,
   output logic d_out
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
   logic [CW-1:0] cnt_q;
   logic out_q;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cnt_q <= '0;
         out_q <= 1'b0;
      end else if (d_in == out_q) begin
         cnt_q <= '0;
      end else if (cnt_q == LAST) begin
         cnt_q <= '0;
         out_q <= d_in;
      end else begin
         cnt_q <= cnt_q + CW'(1);
      end
   end
   assign d_out = out_q;
endmodule

// ---- hdl/mfp_pin_top.sv ----
// multifunction pin control, compare status word and pin configuration register
`include "mfp_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// Function
// R1: protect flag reads 1 while shutdown runs or after it; a status read clears it.
// R2: status bits 7..4 show window compare per channel, held or live by hold setting.
// R3: status bits 3..0 show each comparator result synchronised to the core clock.
// R4: filter on routes the pin through the glitch filter; off bypasses it.
// R5: pin may steer deep sleep only while sleep permission bit is set.
// R6: pin driven only with output enabled; acted on only with input enabled. The code releases a pin reset on a rising edge even with input off.
// R7: output select picks write pending, channel busy or window compare; else low.
// R8: channel mask bit n admits channel n to channel-specific pin actions.
// R9: global functions act device-wide; channel functions only on masked channels.
// R10: function 0000: falling edge enters deep sleep, rising edge leaves it.
// R11: function 0010: falling edge starts a fault snapshot; high level does nothing.
// R12: functions 0011/0100: falling edge powers current/voltage outputs down, rising up.
// R13: function 0101: falling edge starts safe shutdown; high level does nothing.
// R14: function 0111: clear outputs held asserted while the pin stays low.
// R15: function 1000: falling edge strobes load on masked channels with sync selected.
// R16: function 1001: rising edge starts waveforms on masked channels, falling stops.
// R17: function 1010: falling edge triggers margin low, rising edge margin high.
// R18: function 1011: falling edge resets the device, following rising edge releases it.
// R19: after pin reset, unsaved pin configuration is lost and reloads from storage.
// R20: function 1100: falling edge permits storage programming, rising edge blocks it.
// R21: function 1101: falling edge unlocks register writes, rising edge rejects them.
// R22: upper seven status bits carry nothing and read as zero.
// R23: writing a channel hold-clear bit resets its latched window compare; self-clearing.
// R24: undefined input function codes cause no action at all.
// R25: pin synchronised before edge detection; each transition gives one single-cycle event.
module mfp_pin_top
   import mfp_pkg::*;
#(
   parameter int FILTER_CYCLES = (`MFP_FILTER_NS + `MFP_CLK_NS - 1) / `MFP_CLK_NS
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire mfp_reg_req_t reg_req,
   output logic [15:0] reg_rdata_q,
   input wire logic gpio_in,
   output logic gpio_out_q,
   output logic gpio_oe_q,
   input wire logic nonvolatile_write_pending,
   input wire logic [`MFP_NCH-1:0] channel_busy,
   input wire logic [`MFP_NCH-1:0] cmp_raw,
   input wire logic [`MFP_NCH-1:0] win_cmp_raw,
   input wire logic window_hold_on,
   input wire logic [`MFP_NCH-1:0] channel_sync_select,
   input wire logic protect_busy,
   input wire logic [15:0] nvm_cfg_word,
   output logic deep_sleep_q,
   output logic fault_snapshot_q,
   output logic safe_shutdown_q,
   output logic clear_outputs_q,
   output logic device_reset_q,
   output logic nvm_prog_allow_q,
   output logic reg_lock_q,
   output mfp_chan_act_t chan_act_q
);
   ////////////////////////////////////////////////////////////////////////////
   mfp_cfg_t cfg_q;
   logic pin_sync;
   logic pin_filt;
   logic pin_lvl;
   logic pin_prev_q;
   logic pin_rise;
   logic pin_fall;
   logic [2*`MFP_NCH-1:0] cmp_all;
   logic [`MFP_NCH-1:0] cmp_sync;
   logic [`MFP_NCH-1:0] win_sync;
   logic [`MFP_NCH-1:0] win_held_q;
   logic [`MFP_NCH-1:0] win_view;
   logic [`MFP_NCH-1:0] hold_clr;
   logic [`MFP_NCH-1:0] mask;
   logic [`MFP_NCH-1:0] load_sel;
   logic [3:0] func;
   logic [3:0] osel;
   logic in_on;
   logic act_sleep;
   logic act_snap;
   logic act_current_output;
   logic act_voltage_output;
   logic act_prot;
   logic act_clr;
   logic act_load;
   logic act_wave;
   logic act_margin;
   logic act_rst;
   logic act_wp;
   logic act_lock;
   logic rst_release;
   logic wr_ok;
   logic wr_cfg;
   logic wr_trig;
   logic rd_status;
   logic protect_flag_q;
   logic sel_bit;
   logic [15:0] status_word;

   ////////////////////////////////////////////////////////////////////////////
   // pin and comparator inputs
   mfp_pin_sync #(.W(1)) u_pin_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in(gpio_in),
      .sync_out(pin_sync)
   );

   mfp_glitch_filter #(.CYCLES(FILTER_CYCLES)) u_pin_filter (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .d_in(pin_sync),
      .d_out(pin_filt)
   );

   mfp_pin_sync #(.W(2*`MFP_NCH)) u_cmp_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in({win_cmp_raw, cmp_raw}),
      .sync_out(cmp_all)
   );

   assign cmp_sync = cmp_all[`MFP_NCH-1:0]; // R3
   assign win_sync = cmp_all[2*`MFP_NCH-1:`MFP_NCH];

   // toggling the filter while the two paths differ yields one extra edge
   assign pin_lvl = cfg_q.input_filter_on ? pin_filt : pin_sync; // R4

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pin_prev_q <= 1'b0;
      end else begin
         pin_prev_q <= pin_lvl;
      end
   end

   assign pin_rise = pin_lvl & ~pin_prev_q; // R25
   assign pin_fall = ~pin_lvl & pin_prev_q; // R25

   ////////////////////////////////////////////////////////////////////////////
   // input function decode; only listed codes produce an action
   assign in_on = cfg_q.pin_input_on; // R6
   assign func = cfg_q.pin_input_function;
   assign mask = cfg_q.input_channel_mask; // R8
   assign act_sleep = in_on & (func == MFP_IN_SLEEP) & cfg_q.low_power_sleep_allow; // R24
   assign act_snap = in_on & (func == MFP_IN_SNAP); // R24
   assign act_current_output = in_on & (func == MFP_IN_CURRENT_OUTPUT);
   assign act_voltage_output = in_on & (func == MFP_IN_VOLTAGE_OUTPUT);
   assign act_prot = in_on & (func == MFP_IN_PROTECT);
   assign act_clr = in_on & (func == MFP_IN_CLEAR);
   assign act_load = in_on & (func == MFP_IN_LOAD);
   assign act_wave = in_on & (func == MFP_IN_WAVE);
   assign act_margin = in_on & (func == MFP_IN_MARGIN);
   assign act_rst = in_on & (func == MFP_IN_RESET);
   assign act_wp = in_on & (func == MFP_IN_NVM_WP);
   assign act_lock = in_on & (func == MFP_IN_LOCK);
   assign load_sel = mask & channel_sync_select; // R15
   // release does not depend on the function so a changed setting cannot strand reset
   assign rst_release = device_reset_q & pin_rise; // R18

   ////////////////////////////////////////////////////////////////////////////
   // register port decode
   assign wr_ok = reg_req.wr & ~reg_lock_q; // R21
   assign wr_cfg = wr_ok & (reg_req.addr == `MFP_ADDR_CONFIG);
   assign wr_trig = wr_ok & (reg_req.addr == `MFP_ADDR_TRIG);
   assign rd_status = reg_req.rd & (reg_req.addr == `MFP_ADDR_STATUS);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cfg_q <= mfp_cfg_t'(`MFP_CFG_RESET);
      end else if (rst_release) begin
         cfg_q <= mfp_cfg_t'(nvm_cfg_word); // R19
      end else if (wr_cfg) begin
         cfg_q <= mfp_cfg_t'(reg_req.wdata);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // window compare hold, per channel
   for (genvar i = 0; i < `MFP_NCH; i++) begin : g_hold
      assign hold_clr[i] = wr_trig & reg_req.wdata[`MFP_TRIG_CLR_TOP - `MFP_TRIG_STRIDE*i];
      always_ff @(posedge core_clk) begin
         if (sys_rst) begin
            win_held_q[i] <= 1'b0;
         end else if (window_hold_on & win_sync[i]) begin
            win_held_q[i] <= 1'b1; // R2
         end else if (hold_clr[i]) begin
            win_held_q[i] <= 1'b0; // R23
         end
      end
   end

   assign win_view = window_hold_on ? (win_held_q | win_sync) : win_sync; // R2

   ////////////////////////////////////////////////////////////////////////////
   // status word and read data
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         protect_flag_q <= 1'b0;
      end else if (protect_busy | safe_shutdown_q) begin
         protect_flag_q <= 1'b1; // R1
      end else if (rd_status) begin
         protect_flag_q <= 1'b0; // R1
      end
   end

   assign status_word = {7'h00, protect_flag_q, win_view, cmp_sync}; // R22

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reg_rdata_q <= `MFP_STATUS_RESET;
      end else if (reg_req.rd) begin
         case (reg_req.addr)
            `MFP_ADDR_STATUS: reg_rdata_q <= status_word;
            `MFP_ADDR_CONFIG: reg_rdata_q <= cfg_q;
            default: reg_rdata_q <= `MFP_RDATA_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin output
   assign osel = cfg_q.pin_output_select;

   always_comb begin
      sel_bit = 1'b0;
      if (osel == `MFP_OSEL_NVM) begin
         sel_bit = nonvolatile_write_pending; // R7
      end else if (osel[3:2] == `MFP_OSEL_BUSY_HI) begin
         sel_bit = channel_busy[osel[1:0]]; // R7
      end else if (osel[3:2] == `MFP_OSEL_WIN_HI) begin
         sel_bit = win_view[osel[1:0]]; // R7
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         gpio_oe_q <= 1'b0;
         gpio_out_q <= 1'b0;
      end else begin
         gpio_oe_q <= cfg_q.pin_output_on; // R6
         gpio_out_q <= cfg_q.pin_output_on & sel_bit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // global pin actions
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         deep_sleep_q <= 1'b0;
      end else if (!cfg_q.low_power_sleep_allow) begin
         deep_sleep_q <= 1'b0; // R5
      end else if (act_sleep & pin_fall) begin
         deep_sleep_q <= 1'b1; // R10
      end else if (act_sleep & pin_rise) begin
         deep_sleep_q <= 1'b0; // R10
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         fault_snapshot_q <= 1'b0;
         safe_shutdown_q <= 1'b0;
         clear_outputs_q <= 1'b0;
      end else begin
         fault_snapshot_q <= act_snap & pin_fall; // R11
         safe_shutdown_q <= act_prot & pin_fall; // R13
         clear_outputs_q <= act_clr & ~pin_lvl; // R14
      end
   end

   // a sustained low level keeps the device in reset
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         device_reset_q <= 1'b0;
      end else if (rst_release) begin
         device_reset_q <= 1'b0; // R18
      end else if (act_rst & pin_fall) begin
         device_reset_q <= 1'b1; // R18
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         nvm_prog_allow_q <= 1'b1;
      end else if (act_wp & pin_fall) begin
         nvm_prog_allow_q <= 1'b1; // R20
      end else if (act_wp & pin_rise) begin
         nvm_prog_allow_q <= 1'b0; // R20
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reg_lock_q <= 1'b0;
      end else if (act_lock & pin_fall) begin
         reg_lock_q <= 1'b0; // R21
      end else if (act_lock & pin_rise) begin
         reg_lock_q <= 1'b1; // R21
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // channel-specific pin actions, limited to masked channels
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         chan_act_q <= '0;
      end else begin
         chan_act_q.load_strobe <= (act_load & pin_fall) ? load_sel : '0; // R15
         chan_act_q.margin_low <= (act_margin & pin_fall) ? mask : '0; // R17
         chan_act_q.margin_high <= (act_margin & pin_rise) ? mask : '0; // R17
         if (act_current_output & pin_fall) begin
            chan_act_q.current_output_off <= chan_act_q.current_output_off | mask; // R12
         end else if (act_current_output & pin_rise) begin
            chan_act_q.current_output_off <= chan_act_q.current_output_off & ~mask; // R12
         end
         if (act_voltage_output & pin_fall) begin
            chan_act_q.voltage_output_off <= chan_act_q.voltage_output_off | mask; // R9
         end else if (act_voltage_output & pin_rise) begin
            chan_act_q.voltage_output_off <= chan_act_q.voltage_output_off & ~mask; // R12
         end
         if (act_wave & pin_rise) begin
            chan_act_q.wave_run <= chan_act_q.wave_run | mask; // R16
         end else if (act_wave & pin_fall) begin
            chan_act_q.wave_run <= chan_act_q.wave_run & ~mask; // R16
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   property p_flag_set;
      protect_busy |=> protect_flag_q;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("protect flag not set"); // R1

   property p_flag_clear;
      rd_status && !protect_busy && !safe_shutdown_q |=> !protect_flag_q;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // R1

   property p_win_read;
      rd_status && !window_hold_on |=>
         reg_rdata_q[`MFP_ST_WIN_LSB +: `MFP_NCH] == $past(win_sync);
   endproperty
   a_win_read: assert property (p_win_read) else $error("live window bits wrong"); // R2

   property p_cmp_read;
      rd_status |=> reg_rdata_q[`MFP_ST_CMP_LSB +: `MFP_NCH] == $past(cmp_sync);
   endproperty
   a_cmp_read: assert property (p_cmp_read) else $error("compare bits wrong"); // R3

   property p_upper_zero;
      rd_status |=> reg_rdata_q[`MFP_ST_TOP:`MFP_ST_PROTECT+1] == 7'h00;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits set"); // R22

   property p_sleep_off;
      !cfg_q.low_power_sleep_allow |=> !deep_sleep_q;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("sleep not allowed"); // R5

   property p_no_input;
      !cfg_q.pin_input_on |=>
         chan_act_q.load_strobe == '0 && !fault_snapshot_q && !safe_shutdown_q;
   endproperty
   a_no_input: assert property (p_no_input) else $error("action with input off"); // R6

   property p_out_nvm;
      cfg_q.pin_output_on && osel == `MFP_OSEL_NVM |=>
         gpio_oe_q && gpio_out_q == $past(nonvolatile_write_pending);
   endproperty
   a_out_nvm: assert property (p_out_nvm) else $error("pin not showing busy"); // R7

   property p_load_mask;
      act_load && pin_fall |=> chan_act_q.load_strobe == $past(load_sel);
   endproperty
   a_load_mask: assert property (p_load_mask) else $error("load strobe wrong"); // R15

   property p_clear_level;
      act_clr && !pin_lvl |=> clear_outputs_q;
   endproperty
   a_clear_level: assert property (p_clear_level) else $error("clear not held"); // R14

   property p_lock;
      reg_lock_q && reg_req.wr && !rst_release |=> $stable(cfg_q);
   endproperty
   a_lock: assert property (p_lock) else $error("write passed lock"); // R21

   property p_edge_once;
      pin_fall |=> !pin_fall;
   endproperty
   a_edge_once: assert property (p_edge_once) else $error("edge lasted two cycles"); // R25

   property p_reset_release;
      $fell(device_reset_q) |-> $past(pin_rise);
   endproperty
   a_reset_release: assert property (p_reset_release) else $error("reset left early"); // R18

   c_load: cover property (act_load && pin_fall ##1 chan_act_q.load_strobe != '0);
   c_reset: cover property (device_reset_q ##[1:50] !device_reset_q);
   c_flag_read: cover property (protect_flag_q && rd_status ##1 !protect_flag_q);
   c_win_held: cover property (window_hold_on && win_held_q != '0 && win_sync == '0);
endmodule

// ---- dv/mfp_pin_drv.sv ----
// far-side controller model that drives the multifunction pin
module mfp_pin_drv (
   input wire logic core_clk,
   input wire logic gpio_out_q,
   input wire logic gpio_oe_q,
   output logic gpio_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic lvl_q = 1'b1;
   // device drive wins while its enable is high
   assign gpio_in = gpio_oe_q ? gpio_out_q : lvl_q;
   // the level set here holds until the next call, so a low lasts until the bench sets the pin high again
   task automatic set_level(input logic lv);
      @(posedge core_clk);
      #2 lvl_q = lv;
   endtask
endmodule

// ---- dv/tb_mfp_pin_top.sv ----
// self-checking bench for the multifunction pin block
module tb_mfp_pin_top
   import mfp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk, sys_rst, nonvolatile_write_pending, window_hold_on, protect_busy, gpio_in, gpio_out_q;
   logic gpio_oe_q, deep_sleep_q, fault_snapshot_q, safe_shutdown_q, clear_outputs_q;
   logic device_reset_q, nvm_prog_allow_q, reg_lock_q, al, ion, ds, cl, rs, pa, lk, sn, sh, e;
   logic [3:0] channel_busy, cmp_raw, win_cmp_raw, channel_sync_select, f, m;
   logic [3:0] io, vo, wv, ld, ml, mh;
   logic [15:0] reg_rdata_q, nvm_cfg_word, cfg;
   logic [13:0] seen;
   logic [31:0] lf;
   mfp_reg_req_t reg_req;
   mfp_chan_act_t chan_act_q;
   int num_errors, checks_done;
   mfp_pin_top #(.FILTER_CYCLES(4)) u_mfp_pin_top (.core_clk(core_clk), .sys_rst(sys_rst),
      .reg_req(reg_req), .reg_rdata_q(reg_rdata_q), .gpio_in(gpio_in), .gpio_out_q(gpio_out_q),
      .gpio_oe_q(gpio_oe_q), .nonvolatile_write_pending(nonvolatile_write_pending), .channel_busy(channel_busy), .cmp_raw(cmp_raw),
      .win_cmp_raw(win_cmp_raw), .window_hold_on(window_hold_on),
      .channel_sync_select(channel_sync_select), .protect_busy(protect_busy),
      .nvm_cfg_word(nvm_cfg_word), .deep_sleep_q(deep_sleep_q),
      .fault_snapshot_q(fault_snapshot_q), .safe_shutdown_q(safe_shutdown_q),
      .clear_outputs_q(clear_outputs_q), .device_reset_q(device_reset_q),
      .nvm_prog_allow_q(nvm_prog_allow_q), .reg_lock_q(reg_lock_q), .chan_act_q(chan_act_q));
   mfp_pin_drv u_mfp_pin_drv (.core_clk(core_clk), .gpio_out_q(gpio_out_q),
      .gpio_oe_q(gpio_oe_q), .gpio_in(gpio_in));
   ////////////////////////////////////////////////////////////////////////////
   // pulses are one cycle wide, so they are collected between samples
   always @(posedge core_clk) begin
      seen <= seen | {fault_snapshot_q, safe_shutdown_q, chan_act_q.load_strobe,
         chan_act_q.margin_low, chan_act_q.margin_high};
   end
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      wrap_up();
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic rnd;
      lf = lfsr(lf);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_req = {1'b1, 1'b0, a, d};
      cyc(1);
      reg_req = '0;
      cyc(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      reg_req = {1'b0, 1'b1, a, 16'h0000};
      cyc(1);
      reg_req = '0;
      cyc(1);
      chk(reg_rdata_q, exp);
   endtask
   // one pin edge, the expected reaction worked out beside it
   task automatic pe(input logic lv);
      u_mfp_pin_drv.set_level(lv);
      seen = '0;
      {sn, sh, ld, ml, mh} = '0;
      if (ion) begin
         case (f)
            4'h0: if (al) ds = !lv;
            4'h2: sn = !lv;
            4'h3: io = lv ? 4'h0 : m;
            4'h4: vo = lv ? 4'h0 : m;
            4'h5: sh = !lv;
            4'h7: cl = !lv;
            4'h8: ld = lv ? 4'h0 : m & channel_sync_select;
            4'h9: wv = lv ? m : 4'h0;
            4'ha: if (lv) mh = m; else ml = m;
            4'hb: rs = !lv;
            4'hc: pa = !lv;
            4'hd: lk = lv;
            default: ;
         endcase
      end
      cyc(12);
      chk({deep_sleep_q, clear_outputs_q, device_reset_q, nvm_prog_allow_q, reg_lock_q,
         chan_act_q.current_output_off, chan_act_q.voltage_output_off, chan_act_q.wave_run},
         {ds, cl, rs, pa, lk, io, vo, wv});
      chk(seen, {sn, sh, ld, ml, mh});
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      reg_req = '0;
      {nonvolatile_write_pending, window_hold_on, protect_busy, channel_busy, cmp_raw, win_cmp_raw} = '0;
      {channel_sync_select, nvm_cfg_word, seen, num_errors, checks_done} = '0;
      {ds, cl, rs, lk, io, vo, wv} = '0;
      pa = 1'b1;
      lf = 32'h7f05f61d;
      repeat (6) @(posedge core_clk);
      #2 sys_rst = 1'b0;
      cyc(4);
      chk(nvm_prog_allow_q, 1'b1);
      rd(8'h24, 16'h0000);
      rd(8'h23, 16'h0000);
      rd(8'h30, 16'h0000);
      rnd();
      wr(8'h24, lf[15:0] & 16'hfffe);
      rd(8'h24, lf[15:0] & 16'hfffe);
      cmp_raw = lf[19:16];
      win_cmp_raw = lf[23:20];
      cyc(6);
      rd(8'h23, {8'h00, win_cmp_raw, cmp_raw});
      for (int c = 0; c < 17; c++) begin
         rnd();
         nonvolatile_write_pending = lf[8];
         channel_busy = lf[12:9];
         wr(8'h24, {2'b00, c < 16, c[3:0], 9'h000});
         cyc(3);
         e = c[4] ? 1'b0 : c == 1 ? nonvolatile_write_pending : c[3:2] == 2'h1 ? channel_busy[c[1:0]] :
            c[3:2] == 2'h2 ? win_cmp_raw[c[1:0]] : 1'b0;
         chk({gpio_oe_q, gpio_out_q}, {c < 16, e});
      end
      window_hold_on = 1'b1;
      win_cmp_raw = 4'hf;
      cyc(6);
      win_cmp_raw = 4'h0;
      cyc(6);
      rd(8'h23, {8'h00, 4'hf, cmp_raw});
      wr(8'h21, 16'h8000);
      rd(8'h23, {8'h00, 4'he, cmp_raw});
      window_hold_on = 1'b0;
      cyc(4);
      for (int k = 0; k < 18; k++) begin
         rnd();
         f = k == 0 ? 4'h0 : k == 17 ? 4'h2 : 4'(k - 1);
         m = lf[3:0];
         channel_sync_select = lf[7:4];
         // saved word keeps both pin directions off so it cannot disturb later steps
         nvm_cfg_word = lf[31:16] & 16'h1ffe;
         al = k != 0;
         ion = k != 17;
         cfg = {lf[8], al, 1'b0, 4'h0, m, f, ion};
         wr(8'h24, cfg);
         cyc(2);
         pe(1'b0);
         if (f == 4'h5 && ion) begin
            rd(8'h23, {7'h00, 1'b1, 4'h0, cmp_raw});
            rd(8'h23, {8'h00, 4'h0, cmp_raw});
         end
         pe(1'b1);
         if (f == 4'hb) rd(8'h24, nvm_cfg_word);
         if (f == 4'hd) begin
            wr(8'h24, 16'h0000);
            rd(8'h24, cfg);
         end
         if (f == 4'hd || f == 4'h9) pe(1'b0);
         wr(8'h24, 16'h0000);
         u_mfp_pin_drv.set_level(1'b1);
         cyc(8);
      end
      // a two-cycle low glitch passes with the filter off and is dropped with it on
      for (int g = 0; g < 2; g++) begin
         wr(8'h24, {g[0], 10'h000, 4'h2, 1'b1});
         cyc(2);
         u_mfp_pin_drv.set_level(1'b0);
         seen = '0;
         cyc(1);
         u_mfp_pin_drv.set_level(1'b1);
         cyc(12);
         chk(seen[13], !g[0]);
      end
      wr(8'h24, 16'h0000);
      // protect engine busy sets the flag; a read during busy must not clear it
      protect_busy = 1'b1;
      cyc(1);
      rd(8'h23, {7'h00, 1'b1, 4'h0, cmp_raw});
      protect_busy = 1'b0;
      rd(8'h23, {7'h00, 1'b1, 4'h0, cmp_raw});
      rd(8'h23, {8'h00, 4'h0, cmp_raw});
      wrap_up();
   end
endmodule
